/* File: logic/radio_seq_regs.svh */
// Timing counts, state report codes and clock output rate codes of the sequencer.
`ifndef RADIO_SEQ_REGS_SVH
`define RADIO_SEQ_REGS_SVH

// ----------------------------------------------------------------------
// Clock and timing constants
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define T_DEEP_WAKE_US 360
`define T_RAMP_US 80
`define T_FAST_US 1
`define T_TX_START_US 16
`define T_TX_RETURN_US 32
`define T_RESET_WAKE_US 26
`define T_PON_IDLE_US 360
`define T_PON_IDLE_MAX_US 1000
`define CYC_DEEP_WAKE (`T_DEEP_WAKE_US * 1000 / `CLK_PERIOD_NS)
`define CYC_RAMP (`T_RAMP_US * 1000 / `CLK_PERIOD_NS)
`define CYC_FAST (`T_FAST_US * 1000 / `CLK_PERIOD_NS)
`define CYC_TX_START (`T_TX_START_US * 1000 / `CLK_PERIOD_NS)
`define CYC_TX_RETURN (`T_TX_RETURN_US * 1000 / `CLK_PERIOD_NS)
`define CYC_RESET_WAKE (`T_RESET_WAKE_US * 1000 / `CLK_PERIOD_NS)
`define CYC_PON_IDLE (`T_PON_IDLE_US * 1000 / `CLK_PERIOD_NS)
`define CYC_CAL 16
`define TIMER_W 17

// ----------------------------------------------------------------------
// State report codes
// ----------------------------------------------------------------------
`define REP_PON 5'h00
`define REP_TX 5'h02
`define REP_LISTEN 5'h06
`define REP_IDLE 5'h08
`define REP_SYNTH 5'h09
`define REP_SLEEP 5'h0F
`define REP_PREP 5'h10
`define REP_ACK_RX 5'h16
`define REP_RETRY_TX 5'h19
`define REP_PENDING 5'h1F

// ----------------------------------------------------------------------
// Clock output rate
// ----------------------------------------------------------------------
`define CLK_RATE_DEFAULT 3'h1
`define CLK_RATE_OFF 3'h0

`endif

/* File: logic/radio_seq_pkg.sv */
// Types shared by the sequencer files.
package radio_seq_pkg;
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_IDLE = 4'h1,
      CMD_SYNTH = 4'h2,
      CMD_LISTEN = 4'h3,
      CMD_TX_GO = 4'h4,
      CMD_FORCE_IDLE = 4'h5,
      CMD_FORCE_SYNTH = 4'h6,
      CMD_PREP = 4'h7,
      CMD_RETRY_TX = 4'h8,
      CMD_ACK_RX = 4'h9
   } state_command_field_e;

   typedef enum logic [3:0] {
      ST_PON = 4'h0,
      ST_WAKE = 4'h1,
      ST_CAL = 4'h2,
      ST_IDLE = 4'h3,
      ST_RAMP = 4'h4,
      ST_SYNTH = 4'h5,
      ST_LISTEN = 4'h6,
      ST_TX_START = 4'h7,
      ST_TX = 4'h8,
      ST_TX_RETURN = 4'h9,
      ST_PREP = 4'hA,
      ST_DEEP = 4'hB,
      ST_SLEEP = 4'hC,
      ST_MOVE = 4'hD,
      ST_RETRY_TX = 4'hE,
      ST_ACK_RX = 4'hF
   } seq_state_e;

   typedef logic [4:0] report_t;
endpackage

/* File: logic/pin_sync.sv */
// Two-flop synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign level_o = sync_r;
   assign rise_o = sync_r & ~last_r;
   assign fall_o = ~sync_r & last_r;
endmodule
`default_nettype wire

/* File: logic/radio_state_transition_sequencer.sv */
// State transition sequencer of the radio transceiver.
`timescale 1ns/1ps
`default_nettype none
`include "radio_seq_regs.svh"

// What this block does
// - Sleep pin low wakes deep power-down in 360us.
// - Clock output restarts at default rate after pin wake.
// - Filter calibration runs before idle is declared on wake or reset.
// - Ready command from idle ramps regulator 80us.
// - Listen from idle is reported at once.
// - Ready and listen swap anytime in 1us.
// - Pin rise or transmit-go in ready transmits after 16us.
// - Frame done event, 32us return, then ready.
// - Receive request during transmit ends in listen.
// - Reset restores defaults except clock rate bits.
// - Reset release outside sleep calibrates, idle after 26us.
// - Reset from sleep restarts oscillator and regulator.
// - Reset cancels any queued state command.
// - Idle command from power-on reaches idle 360us.
// - Force idle reaches idle in 1us, not sleeping.
// - Force ready reaches ready in 1us, restricted.
// - Retry-transmit and ack-receive entry take 1us.
// - Timing starts at end of command or edge.
// - Pending code reported while transition incomplete.
module radio_state_transition_sequencer (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sleep_transmit_pin_i,
   input wire logic cmd_valid_i,
   input wire radio_seq_pkg::state_command_field_e cmd_i,
   input wire logic [2:0] clock_output_rate_bits_i,
   input wire logic clock_rate_write_i,
   input wire logic frame_sent_i,
   input wire logic synth_lock_i,
   output radio_seq_pkg::report_t state_report_field_o,
   output logic [2:0] clock_output_rate_bits_o,
   output logic crystal_oscillator_en_o,
   output logic digital_regulator_en_o,
   output logic analog_regulator_en_o,
   output logic filter_tuning_calibration_o,
   output logic tx_active_o,
   output logic frame_done_event_o,
   output logic synth_lock_event_o
);
   import radio_seq_pkg::*;

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   logic slp_level;
   logic slp_rise;
   logic slp_fall;
   logic lock_level;
   logic lock_rise;

   pin_sync u_slp_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .pin_i(sleep_transmit_pin_i),
      .level_o(slp_level),
      .rise_o(slp_rise),
      .fall_o(slp_fall)
   );

   pin_sync u_lock_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .pin_i(synth_lock_i),
      .level_o(lock_level),
      .rise_o(lock_rise),
      .fall_o()
   );

   // -------------------------------------------------------------------
   // Sequencer state
   // -------------------------------------------------------------------
   seq_state_e state_r;
   seq_state_e target_r;
   logic [`TIMER_W-1:0] timer_r;
   logic listen_after_tx_r;
   logic was_asleep_r;
   logic reset_seen_r;
   logic timer_done;
   logic rx_req;

   assign timer_done = (timer_r == '0);
   assign rx_req = cmd_valid_i &&
      (cmd_i == CMD_LISTEN || cmd_i == CMD_ACK_RX);

   // Records that the core came out of reset so the wake sequence runs.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         reset_seen_r <= 1'b1;
      end else begin
         reset_seen_r <= 1'b0;
      end
   end

   // Main transition engine; a reset drops any command in flight.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state_r <= ST_PON;
         target_r <= ST_IDLE;
         timer_r <= '0;
         listen_after_tx_r <= 1'b0;
      end else if (reset_seen_r && was_asleep_r) begin
         state_r <= ST_WAKE;
         target_r <= ST_IDLE;
         timer_r <= `TIMER_W'(`CYC_DEEP_WAKE - `CYC_CAL);
      end else if (reset_seen_r) begin
         state_r <= ST_CAL;
         target_r <= ST_IDLE;
         timer_r <= `TIMER_W'(`CYC_RESET_WAKE);
      end else begin
         if (!timer_done) begin
            timer_r <= timer_r - `TIMER_W'(1);
         end
         unique case (state_r)
            ST_PON: begin
               if (cmd_valid_i && cmd_i == CMD_IDLE) begin
                  state_r <= ST_WAKE;
                  target_r <= ST_IDLE;
                  timer_r <= `TIMER_W'(`CYC_PON_IDLE - `CYC_CAL);
               end
            end
            ST_WAKE: begin
               if (timer_done) begin
                  state_r <= ST_CAL;
                  timer_r <= `TIMER_W'(`CYC_CAL);
               end
            end
            ST_CAL: begin
               if (timer_done) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_DEEP, ST_SLEEP: begin
               if (slp_fall) begin
                  state_r <= ST_WAKE;
                  target_r <= ST_IDLE;
                  timer_r <= `TIMER_W'(`CYC_DEEP_WAKE - `CYC_CAL);
               end
            end
            ST_IDLE: begin
               if (cmd_valid_i && cmd_i == CMD_SYNTH) begin
                  state_r <= ST_RAMP;
                  target_r <= ST_SYNTH;
                  timer_r <= `TIMER_W'(`CYC_RAMP);
               end else if (cmd_valid_i && cmd_i == CMD_LISTEN) begin
                  state_r <= ST_LISTEN;
               end else if (cmd_valid_i && cmd_i == CMD_PREP) begin
                  state_r <= ST_MOVE;
                  target_r <= ST_PREP;
                  timer_r <= `TIMER_W'(`CYC_FAST);
               end else if (cmd_valid_i && cmd_i == CMD_FORCE_SYNTH) begin
                  state_r <= ST_MOVE;
                  target_r <= ST_SYNTH;
                  timer_r <= `TIMER_W'(`CYC_FAST);
               end
            end
            ST_PREP: begin
               if (cmd_valid_i && (cmd_i == CMD_IDLE ||
                   cmd_i == CMD_FORCE_IDLE)) begin
                  state_r <= ST_MOVE;
                  target_r <= ST_IDLE;
                  timer_r <= `TIMER_W'(`CYC_FAST);
               end else if (slp_rise) begin
                  state_r <= ST_DEEP;
               end
            end
            ST_RAMP, ST_MOVE: begin
               if (cmd_valid_i && cmd_i == CMD_FORCE_IDLE) begin
                  target_r <= ST_IDLE;
                  timer_r <= `TIMER_W'(`CYC_FAST);
               end else if (timer_done) begin
                  state_r <= target_r;
               end
            end
            ST_SYNTH, ST_LISTEN, ST_RETRY_TX, ST_ACK_RX: begin
               if (cmd_valid_i) begin
                  unique case (cmd_i)
                     CMD_SYNTH, CMD_FORCE_SYNTH: begin
                        state_r <= ST_MOVE;
                        target_r <= ST_SYNTH;
                        timer_r <= `TIMER_W'(`CYC_FAST);
                     end
                     CMD_LISTEN: begin
                        state_r <= ST_MOVE;
                        target_r <= ST_LISTEN;
                        timer_r <= `TIMER_W'(`CYC_FAST);
                     end
                     CMD_RETRY_TX: begin
                        state_r <= ST_MOVE;
                        target_r <= ST_RETRY_TX;
                        timer_r <= `TIMER_W'(`CYC_FAST);
                     end
                     CMD_ACK_RX: begin
                        state_r <= ST_MOVE;
                        target_r <= ST_ACK_RX;
                        timer_r <= `TIMER_W'(`CYC_FAST);
                     end
                     CMD_IDLE, CMD_FORCE_IDLE: begin
                        state_r <= ST_MOVE;
                        target_r <= ST_IDLE;
                        timer_r <= `TIMER_W'(`CYC_FAST);
                     end
                     CMD_TX_GO: begin
                        if (state_r == ST_SYNTH) begin
                           state_r <= ST_TX_START;
                           timer_r <= `TIMER_W'(`CYC_TX_START);
                        end
                     end
                     default: begin
                     end
                  endcase
               end else if (slp_rise && state_r == ST_SYNTH) begin
                  state_r <= ST_TX_START;
                  timer_r <= `TIMER_W'(`CYC_TX_START);
               end
            end
            ST_TX_START, ST_TX, ST_TX_RETURN: begin
               if (cmd_valid_i && cmd_i == CMD_FORCE_IDLE) begin
                  state_r <= ST_MOVE;
                  target_r <= ST_IDLE;
                  timer_r <= `TIMER_W'(`CYC_FAST);
                  listen_after_tx_r <= 1'b0;
               end else if (cmd_valid_i && cmd_i == CMD_FORCE_SYNTH) begin
                  state_r <= ST_MOVE;
                  target_r <= ST_SYNTH;
                  timer_r <= `TIMER_W'(`CYC_FAST);
                  listen_after_tx_r <= 1'b0;
               end else begin
                  if (rx_req) begin
                     listen_after_tx_r <= 1'b1;
                  end
                  if (state_r == ST_TX_START && timer_done) begin
                     state_r <= ST_TX;
                  end else if (state_r == ST_TX && frame_sent_i) begin
                     state_r <= ST_TX_RETURN;
                     timer_r <= `TIMER_W'(`CYC_TX_RETURN);
                  end else if (state_r == ST_TX_RETURN && timer_done) begin
                     state_r <= (listen_after_tx_r || rx_req) ? ST_LISTEN :
                        ST_SYNTH;
                     listen_after_tx_r <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // Remembers whether a sleep state was left by reset; kept across reset.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_i) begin
         was_asleep_r <= (state_r == ST_DEEP) || (state_r == ST_SLEEP);
      end
   end

   // -------------------------------------------------------------------
   // Clock output rate; not touched by reset
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (state_r == ST_WAKE && was_asleep_r) begin
         clock_output_rate_bits_o <= `CLK_RATE_DEFAULT;
      end else if (state_r == ST_DEEP) begin
         clock_output_rate_bits_o <= `CLK_RATE_OFF;
      end else if (clock_rate_write_i) begin
         clock_output_rate_bits_o <= clock_output_rate_bits_i;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state_report_field_o <= `REP_PENDING;
      end else begin
         unique case (state_r)
            ST_PON: begin
               state_report_field_o <= reset_seen_r ? `REP_PENDING : `REP_PON;
            end
            ST_IDLE: state_report_field_o <= `REP_IDLE;
            ST_SYNTH: state_report_field_o <= `REP_SYNTH;
            ST_LISTEN: state_report_field_o <= `REP_LISTEN;
            ST_TX: state_report_field_o <= `REP_TX;
            ST_PREP: state_report_field_o <= `REP_PREP;
            ST_DEEP, ST_SLEEP: state_report_field_o <= `REP_SLEEP;
            ST_RETRY_TX: state_report_field_o <= `REP_RETRY_TX;
            ST_ACK_RX: state_report_field_o <= `REP_ACK_RX;
            default: state_report_field_o <= `REP_PENDING;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         crystal_oscillator_en_o <= 1'b1;
         digital_regulator_en_o <= 1'b1;
         analog_regulator_en_o <= 1'b0;
         filter_tuning_calibration_o <= 1'b0;
         tx_active_o <= 1'b0;
         frame_done_event_o <= 1'b0;
         synth_lock_event_o <= 1'b0;
      end else begin
         crystal_oscillator_en_o <= (state_r != ST_DEEP);
         digital_regulator_en_o <= (state_r != ST_DEEP);
         analog_regulator_en_o <= !(state_r inside {ST_PON, ST_WAKE,
            ST_CAL, ST_IDLE, ST_PREP, ST_DEEP, ST_SLEEP});
         filter_tuning_calibration_o <= (state_r == ST_CAL);
         tx_active_o <= (state_r == ST_TX);
         frame_done_event_o <= (state_r == ST_TX) && frame_sent_i;
         synth_lock_event_o <= lock_rise && lock_level;
      end
   end
endmodule
`default_nettype wire

/* File: tb/radio_seq_props.sv */
// Port-level assertions for the radio state transition sequencer.
`timescale 1ns/1ps
`default_nettype none
module radio_seq_props (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sleep_transmit_pin_i,
   input wire logic cmd_valid_i,
   input wire radio_seq_pkg::state_command_field_e cmd_i,
   input wire logic clock_rate_write_i,
   input wire logic frame_sent_i,
   input wire logic synth_lock_i,
   input wire radio_seq_pkg::report_t state_report_field_o,
   input wire logic [2:0] clock_output_rate_bits_o,
   input wire logic crystal_oscillator_en_o,
   input wire logic digital_regulator_en_o,
   input wire logic analog_regulator_en_o,
   input wire logic filter_tuning_calibration_o,
   input wire logic tx_active_o,
   input wire logic frame_done_event_o,
   input wire logic synth_lock_event_o
);
   import radio_seq_pkg::*;
   logic [15:0] rel_cnt_r;
   logic woke_r;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);
   // Cycles since reset release, saturating.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         rel_cnt_r <= 16'h0000;
      end else if (rel_cnt_r != 16'hFFFF) begin
         rel_cnt_r <= rel_cnt_r + 16'h0001;
      end
   end
   // Set while the oscillator is off, cleared by a rate write.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         woke_r <= 1'b0;
      end else if (clock_rate_write_i) begin
         woke_r <= 1'b0;
      end else if (!crystal_oscillator_en_o) begin
         woke_r <= 1'b1;
      end
   end
   a_reset_wake_time: assert property (
      (state_report_field_o == 5'h08 && $past(state_report_field_o) == 5'h1F
       && rel_cnt_r < 16'h0BB8) |-> rel_cnt_r >= 16'h0A1E)
      else $error("idle reached too early after reset");
   a_ramp_pending: assert property (
      (cmd_valid_i && cmd_i == CMD_SYNTH && state_report_field_o == 5'h08)
      |-> ##2 (state_report_field_o == 5'h1F && analog_regulator_en_o))
      else $error("ramp did not start or report not pending");
   a_listen_fast: assert property (
      (cmd_valid_i && cmd_i == CMD_LISTEN && state_report_field_o == 5'h08)
      |-> ##[1:3] state_report_field_o == 5'h06)
      else $error("listen not reported at once");
   a_cal_then_idle: assert property (
      $fell(filter_tuning_calibration_o)
      |-> ##[0:2] state_report_field_o == 5'h08)
      else $error("calibration end not followed by idle");
   a_done_follows: assert property (
      tx_active_o && frame_sent_i |=> frame_done_event_o)
      else $error("frame done event missing");
   a_done_cause: assert property (
      frame_done_event_o |-> $past(frame_sent_i) && $past(tx_active_o))
      else $error("frame done event without a finished frame");
   a_wake_restart: assert property (
      (!crystal_oscillator_en_o && $fell(sleep_transmit_pin_i))
      |-> ##[1:6] (crystal_oscillator_en_o && digital_regulator_en_o))
      else $error("oscillator not restarted by pin release");
   a_supplies_off: assert property (
      !crystal_oscillator_en_o
      |-> !digital_regulator_en_o && !analog_regulator_en_o)
      else $error("regulators on while oscillator off");
   a_wake_rate: assert property (
      (woke_r && state_report_field_o == 5'h08)
      |-> clock_output_rate_bits_o == 3'h1)
      else $error("clock output rate not default after wake");
   a_force_idle: assert property (
      (cmd_valid_i && cmd_i == CMD_FORCE_IDLE && state_report_field_o inside
       {5'h02, 5'h06, 5'h09, 5'h10, 5'h16, 5'h19})
      |-> ##[95:110] state_report_field_o == 5'h08)
      else $error("force idle too slow");
   a_lock_event: assert property (
      ($past(synth_lock_i, 3) && !$past(synth_lock_i, 4))
      |-> synth_lock_event_o)
      else $error("lock rise gave no lock event");
endmodule
bind radio_state_transition_sequencer radio_seq_props i_props (.clk_sys_i,
   .reset_i, .sleep_transmit_pin_i, .cmd_valid_i, .cmd_i, .clock_rate_write_i,
   .frame_sent_i, .state_report_field_o, .clock_output_rate_bits_o,
   .crystal_oscillator_en_o, .digital_regulator_en_o, .analog_regulator_en_o,
   .filter_tuning_calibration_o, .tx_active_o, .frame_done_event_o,
   .synth_lock_i, .synth_lock_event_o);
`default_nettype wire

/* File: tb/radio_host_model.sv */
// Host side model: command strobes and the sleep/transmit pin.
`timescale 1ns/1ps
`default_nettype none
module radio_host_model (
   input wire logic clk_sys_i,
   input wire radio_seq_pkg::report_t state_report_field_i,
   output logic cmd_valid_o,
   output radio_seq_pkg::state_command_field_e cmd_o,
   output logic sleep_transmit_pin_o
);
   import radio_seq_pkg::*;
   logic link_clk;
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = CMD_NONE;
      sleep_transmit_pin_o = 1'b0;
      link_clk = 1'b0;
      forever #62.5 link_clk = ~link_clk;
   end
   // Holds the command back while a transition is pending.
   task automatic send(input state_command_field_e c);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (state_report_field_i === 5'h1F && n < 40000);
      @(posedge clk_sys_i);
      cmd_o <= c;
      cmd_valid_o <= 1'b1;
      @(posedge clk_sys_i);
      cmd_valid_o <= 1'b0;
      cmd_o <= state_command_field_e'(~c);
   endtask
   task automatic set_pin(input logic v);
      @(posedge link_clk);
      sleep_transmit_pin_o <= v;
   endtask
endmodule
`default_nettype wire

/* File: tb/radio_state_transition_sequencer_bench.sv */
// Self-checking bench for the radio state transition sequencer.
`timescale 1ns/1ps
`default_nettype none
module radio_state_transition_sequencer_bench;
   import radio_seq_pkg::*;
   logic clk_sys_i, reset_i, pin, cmd_valid, rate_wr, frame_sent, lock;
   logic osc, dreg, areg, cal, tx_act, done, lock_ev;
   logic [2:0] rate_in, rate_o, rate_set;
   state_command_field_e cmd;
   report_t rep;
   int error_cnt, tests_run, seed, t;
   state_command_field_e seq_c[11] = '{CMD_LISTEN, CMD_FORCE_IDLE, CMD_SYNTH,
      CMD_LISTEN, CMD_SYNTH, CMD_RETRY_TX, CMD_FORCE_SYNTH, CMD_ACK_RX,
      CMD_FORCE_IDLE, CMD_FORCE_SYNTH, CMD_TX_GO};
   int seq_us[11] = '{0, 1, 80, 1, 1, 1, 1, 1, 1, 1, 16};
   radio_state_transition_sequencer i_dut (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .sleep_transmit_pin_i(pin), .cmd_valid_i(cmd_valid),
      .cmd_i(cmd), .clock_output_rate_bits_i(rate_in),
      .clock_rate_write_i(rate_wr), .frame_sent_i(frame_sent),
      .synth_lock_i(lock), .state_report_field_o(rep),
      .clock_output_rate_bits_o(rate_o), .crystal_oscillator_en_o(osc),
      .digital_regulator_en_o(dreg), .analog_regulator_en_o(areg),
      .filter_tuning_calibration_o(cal), .tx_active_o(tx_act),
      .frame_done_event_o(done), .synth_lock_event_o(lock_ev));
   radio_host_model i_host (.clk_sys_i(clk_sys_i), .state_report_field_i(rep),
      .cmd_valid_o(cmd_valid), .cmd_o(cmd), .sleep_transmit_pin_o(pin));
   // ------------------------------------------------------------------
   // Expectations and checks
   // ------------------------------------------------------------------
   function automatic int cyc(input int us);
      return us * 100;
   endfunction
   function automatic report_t code_of(input state_command_field_e c);
      case (c)
         CMD_LISTEN: return 5'h06;
         CMD_TX_GO: return 5'h02;
         CMD_IDLE, CMD_FORCE_IDLE: return 5'h08;
         CMD_PREP: return 5'h10;
         CMD_ACK_RX: return 5'h16;
         CMD_RETRY_TX: return 5'h19;
         default: return 5'h09;
      endcase
   endfunction
   task automatic chk_code(input string what, input report_t exp,
      input report_t got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_val(input string what, input logic [2:0] exp,
      input logic [2:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_time(input string what, input int lo, input int hi,
      input int got);
      tests_run++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("FAIL %s expected %0d to %0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic wait_code(input report_t exp, input int maxc);
      t = 0;
      do begin
         @(negedge clk_sys_i);
         t++;
      end while (rep !== exp && t < maxc);
      chk_code("state report", exp, rep);
   endtask
   task automatic do_cmd(input state_command_field_e c, input int us);
      @(posedge clk_sys_i);
      rate_in <= 3'($random(seed));
      lock <= 1'($random(seed));
      i_host.send(c);
      wait_code(code_of(c), 2 * cyc(us) + 300);
      chk_time("transition time", cyc(us) - 10, cyc(us) + 30, t);
   endtask
   task automatic wr_rate();
      @(posedge clk_sys_i);
      rate_set = 3'($random(seed));
      rate_in <= rate_set;
      rate_wr <= 1'b1;
      @(posedge clk_sys_i);
      rate_wr <= 1'b0;
      @(negedge clk_sys_i);
      chk_val("rate bits", rate_set, rate_o);
   endtask
   task automatic frame();
      repeat (5 + ($unsigned($random(seed)) % 50)) @(posedge clk_sys_i);
      frame_sent <= 1'b1;
      @(posedge clk_sys_i);
      frame_sent <= 1'b0;
      @(negedge clk_sys_i);
      chk_val("frame done", 3'h1, {2'b00, done});
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (80000) @(posedge clk_sys_i);
      error_cnt++;
      give_verdict();
   end
   initial begin
      seed = 74;
      error_cnt = 0;
      tests_run = 0;
      reset_i = 1'b1;
      rate_in = 3'h0;
      rate_wr = 1'b0;
      frame_sent = 1'b0;
      lock = 1'b0;
      repeat (10) @(posedge clk_sys_i);
      chk_code("reset report", 5'h1F, rep);
      chk_val("reset supplies", 3'h6, {osc, dreg, areg});
      reset_i <= 1'b0;
      wait_code(5'h08, 3000);
      chk_time("reset wake", 2590, 2700, t);
      wr_rate();
      for (int i = 0; i < 11; i++) begin
         do_cmd(seq_c[i], seq_us[i]);
      end
      chk_val("tx active", 3'h1, {2'b00, tx_act});
      frame();
      wait_code(5'h09, 3500);
      chk_time("tx return", 3190, 3230, t);
      i_host.set_pin(1'b1);
      wait_code(5'h02, 2000);
      chk_time("pin tx start", 1590, 1650, t);
      i_host.set_pin(1'b0);
      i_host.send(CMD_LISTEN);
      frame();
      wait_code(5'h06, 3500);
      do_cmd(CMD_FORCE_IDLE, 1);
      do_cmd(CMD_PREP, 1);
      do_cmd(CMD_IDLE, 1);
      do_cmd(CMD_PREP, 1);
      i_host.set_pin(1'b1);
      wait_code(5'h0F, 300);
      chk_val("deep supplies", 3'h0, {osc, dreg, areg});
      i_host.set_pin(1'b0);
      wait_code(5'h08, 37000);
      chk_time("deep wake", 35990, 36100, t);
      chk_val("wake rate", 3'h1, rate_o);
      wr_rate();
      i_host.send(CMD_SYNTH);
      reset_i <= 1'b1;
      repeat (70) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      repeat (70) @(posedge clk_sys_i);
      wait_code(5'h08, 3000);
      repeat (100) @(negedge clk_sys_i);
      chk_code("after reset", 5'h08, rep);
      chk_val("rate kept", rate_set, rate_o);
      give_verdict();
   end
endmodule
`default_nettype wire
